// ===== pkg/srcc_pkg.sv
// Constants shared by the receive-channel configuration and datapath
//
// Overview of operation
// - Framing-character select at 1 makes the framer hunt for the K28.5 comma.
// - Decode style 1 gives native special-character output, 0 gives the alternate form.
// - Decoder enable 1 decodes 10B/8B; 0 passes raw 10-bit characters through.
// - Clock source 0 loads the output register from the recovered character timing.
// - Clock source 1 uses the reference clock; elastic buffer inserts or deletes K28.5.
// - Rate 1 gives complementary output clocks at half the character rate.
// - Rate 0 gives complementary full-rate output clocks at the character rate.
// - Framer mode "10" realigns only on two commas within 50 bits, same boundary.
package srcc_pkg;

    // ------------------------------------------------------------------
    // Character and framing geometry
    // ------------------------------------------------------------------
    localparam int CHAR_BITS       = 10;
    localparam int FRAME_SPAN_BITS = 50;
    localparam int MAX_DET_DIST    = FRAME_SPAN_BITS - CHAR_BITS;
    localparam int CLK_HIGH_CYCLES = CHAR_BITS / 2;
    localparam int FIFO_DEPTH      = 4;
    localparam int WORD_W          = 11;

    // ------------------------------------------------------------------
    // Register map (byte addresses on the 4-bit port)
    // ------------------------------------------------------------------
    localparam int       ADDR_W    = 4;
    localparam int       DATA_W    = 8;
    localparam bit [3:0] CFG_BASE  = 4'h0;
    localparam bit [3:0] STAT_BASE = 4'h4;
    localparam bit [7:0] CFG_RESET = 8'h00;

    // Configuration latch fields
    localparam int FMODE_LSB  = 0;
    localparam int FCHAR_BIT  = 2;
    localparam int DSTYLE_BIT = 3;
    localparam int DECEN_BIT  = 4;
    localparam int CSRC_BIT   = 5;
    localparam int RATE_BIT   = 6;

    // Status fields
    localparam int ST_FRAMED   = 0;
    localparam int ST_CODE_ERR = 1;
    localparam int ST_OVERFLOW = 2;
    localparam int ST_INSERT   = 3;
    localparam int ST_DELETE   = 4;

    // Framer modes
    localparam bit [1:0] FMODE_OFF    = 2'h0;
    localparam bit [1:0] FMODE_SINGLE = 2'h1;
    localparam bit [1:0] FMODE_MULTI  = 2'h2;

    // Comma patterns, first transmitted bit in the MSB
    localparam bit [9:0] K28_5_RDN  = 10'h0fa;
    localparam bit [9:0] K28_5_RDP  = 10'h305;
    localparam bit [6:0] COMMA_RDN  = 7'h1f;
    localparam bit [6:0] COMMA_RDP  = 7'h60;
    localparam bit [5:0] K28_6B_RDN = 6'h0f;
    localparam bit [5:0] K28_6B_RDP = 6'h30;

endpackage

// ===== rtl/srcc_fifo.sv
// Small synchronous FIFO used as the receive elasticity buffer
`timescale 1ns/1ps
module srcc_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW:0]      count_reg;
    logic             push;
    logic             pop;

    // Honest flags straight from the occupancy count
    assign in_ready  = (count_reg != (PW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage write
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

// ===== rtl/srcc_rx_channel.sv
// Receive channel: config latches, framer, 10B/8B decoder, output clocking
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module srcc_rx_channel #(
    parameter bit [1:0] CHAN_ID = 2'h0
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  cfg_addr,
    input  wire logic [7:0]  cfg_wdata,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    output logic      [7:0]  cfg_rdata,
    input  wire logic        ser_bit,
    input  wire logic        ser_bit_valid,
    input  wire logic        local_reference_clock,
    output logic      [9:0]  rx_char_data,
    output logic             rx_char_special,
    output logic             rx_out_clk_true,
    output logic             rx_out_clk_comp
);
    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Returns {valid, EDCBA}
    function automatic logic [5:0] dec6(input logic [5:0] s);
        unique case (s)
            6'h27, 6'h18: dec6 = 6'h20; 6'h1d, 6'h22: dec6 = 6'h21;
            6'h2d, 6'h12: dec6 = 6'h22; 6'h31:        dec6 = 6'h23;
            6'h35, 6'h0a: dec6 = 6'h24; 6'h29:        dec6 = 6'h25;
            6'h19:        dec6 = 6'h26; 6'h38, 6'h07: dec6 = 6'h27;
            6'h39, 6'h06: dec6 = 6'h28; 6'h25:        dec6 = 6'h29;
            6'h15:        dec6 = 6'h2a; 6'h34:        dec6 = 6'h2b;
            6'h0d:        dec6 = 6'h2c; 6'h2c:        dec6 = 6'h2d;
            6'h1c:        dec6 = 6'h2e; 6'h17, 6'h28: dec6 = 6'h2f;
            6'h1b, 6'h24: dec6 = 6'h30; 6'h23:        dec6 = 6'h31;
            6'h13:        dec6 = 6'h32; 6'h32:        dec6 = 6'h33;
            6'h0b:        dec6 = 6'h34; 6'h2a:        dec6 = 6'h35;
            6'h1a:        dec6 = 6'h36; 6'h3a, 6'h05: dec6 = 6'h37;
            6'h33, 6'h0c: dec6 = 6'h38; 6'h26:        dec6 = 6'h39;
            6'h16:        dec6 = 6'h3a; 6'h36, 6'h09: dec6 = 6'h3b;
            6'h0e, 6'h0f, 6'h30: dec6 = 6'h3c;
            6'h2e, 6'h11: dec6 = 6'h3d; 6'h1e, 6'h21: dec6 = 6'h3e;
            6'h2b, 6'h14: dec6 = 6'h3f;
            default:      dec6 = 6'h00;
        endcase
    endfunction

    // Returns {valid, HGF}
    function automatic logic [3:0] dec4(input logic [3:0] f);
        unique case (f)
            4'hb, 4'h4: dec4 = 4'h8; 4'h9:       dec4 = 4'h9;
            4'h5:       dec4 = 4'ha; 4'hc, 4'h3: dec4 = 4'hb;
            4'hd, 4'h2: dec4 = 4'hc; 4'ha:       dec4 = 4'hd;
            4'h6:       dec4 = 4'he;
            4'he, 4'h1, 4'h7, 4'h8: dec4 = 4'hf;
            default:    dec4 = 4'h0;
        endcase
    endfunction

    // Builds the FIFO/output word {special, data[9:0]} from a raw character
    function automatic logic [10:0] make_word(input logic [9:0] raw, input logic dec_en,
                                              input logic native);
        logic [5:0] d6;
        logic [3:0] d4;
        logic       k28;
        logic       kalt;
        logic       spec;
        logic       err;
        k28  = (raw[9:4] == srcc_pkg::K28_6B_RDN) || (raw[9:4] == srcc_pkg::K28_6B_RDP);
        // K28 with positive disparity carries an inverted tail
        d4   = dec4((raw[9:4] == srcc_pkg::K28_6B_RDP) ? ~raw[3:0] : raw[3:0]);
        d6   = dec6(raw[9:4]);
        kalt = ((raw[3:0] == 4'h7) || (raw[3:0] == 4'h8)) &&
               ((d6[4:0] == 5'h17) || (d6[4:0] == 5'h1b) ||
                (d6[4:0] == 5'h1d) || (d6[4:0] == 5'h1e));
        spec = k28 || kalt;
        err  = !d6[5] || !d4[3];
        if (!dec_en) begin
            make_word = {1'b0, raw};
        end else if (native) begin
            make_word = {spec, 1'b0, err, d4[2:0], d6[4:0]};
        end else begin
            make_word = {1'b0, spec, err, d4[2:0], d6[4:0]};
        end
    endfunction

    // ------------------------------------------------------------------
    // Configuration and status latches
    // ------------------------------------------------------------------
    logic [7:0] cfg_reg;
    logic [4:0] stat_reg;
    logic [7:0] cfg_rdata_reg;
    logic       cfg_hit;
    logic       stat_hit;

    logic [1:0] fmode;
    logic       fchar;
    logic       native;
    logic       dec_en;
    logic       src_ref;
    logic       half_rate;

    // Only this channel's own addresses reach its latches
    assign cfg_hit   = (cfg_addr == (srcc_pkg::CFG_BASE | {2'h0, CHAN_ID}));
    assign stat_hit  = (cfg_addr == (srcc_pkg::STAT_BASE | {2'h0, CHAN_ID}));
    assign fmode     = cfg_reg[srcc_pkg::FMODE_LSB +: 2];
    assign fchar     = cfg_reg[srcc_pkg::FCHAR_BIT];
    assign native    = cfg_reg[srcc_pkg::DSTYLE_BIT];
    assign dec_en    = cfg_reg[srcc_pkg::DECEN_BIT];
    assign src_ref   = cfg_reg[srcc_pkg::CSRC_BIT];
    assign half_rate = cfg_reg[srcc_pkg::RATE_BIT];
    assign cfg_rdata = cfg_rdata_reg;

    // Configuration latch write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfg_reg <= srcc_pkg::CFG_RESET;
        end else if (cfg_wr && cfg_hit) begin
            cfg_reg <= cfg_wdata;
        end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge sys_clk) begin
        if (rst || !cfg_rd) begin
            cfg_rdata_reg <= 8'h00;
        end else if (cfg_hit) begin
            cfg_rdata_reg <= cfg_reg;
        end else if (stat_hit) begin
            cfg_rdata_reg <= {3'h0, stat_reg};
        end else begin
            cfg_rdata_reg <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Framer
    // ------------------------------------------------------------------
    logic [9:0] sh_reg;
    logic [9:0] sh_next;
    logic [3:0] bitpos_reg;
    logic [5:0] dist_reg;
    logic [5:0] dist_next;
    logic       seen_reg;
    logic       comma_hit;
    logic       pair_ok;
    logic       realign;
    logic       char_end;
    logic       is_k285;

    assign sh_next   = {sh_reg[8:0], ser_bit};
    assign is_k285   = (sh_next == srcc_pkg::K28_5_RDN) || (sh_next == srcc_pkg::K28_5_RDP);
    // Full K28.5 when selected, else any 7-bit comma
    assign comma_hit = ser_bit_valid && (fchar ? is_k285 :
                       ((sh_next[9:3] == srcc_pkg::COMMA_RDN) ||
                        (sh_next[9:3] == srcc_pkg::COMMA_RDP)));
    assign dist_next = (dist_reg == 6'h3f) ? dist_reg : dist_reg + 6'h01;
    // Second comma within the span and on a whole-character spacing
    assign pair_ok   = seen_reg && (dist_next <= 6'(srcc_pkg::MAX_DET_DIST)) &&
                       ((dist_next % 6'(srcc_pkg::CHAR_BITS)) == 6'h00);
    assign realign   = comma_hit && ((fmode == srcc_pkg::FMODE_SINGLE) ||
                       ((fmode == srcc_pkg::FMODE_MULTI) && pair_ok));
    assign char_end  = ser_bit_valid &&
                       ((bitpos_reg == 4'(srcc_pkg::CHAR_BITS - 1)) || realign);

    // Deserializer shift register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sh_reg <= 10'h000;
        end else if (ser_bit_valid) begin
            sh_reg <= sh_next;
        end
    end

    // Character boundary counter; a realign closes the character on this bit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bitpos_reg <= 4'h0;
        end else if (char_end) begin
            bitpos_reg <= 4'h0;
        end else if (ser_bit_valid) begin
            bitpos_reg <= bitpos_reg + 4'h1;
        end
    end

    // Distance since the last comma, saturating so stale commas never pair up
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dist_reg <= 6'h3f;
            seen_reg <= 1'b0;
        end else if (comma_hit) begin
            dist_reg <= 6'h00;
            seen_reg <= 1'b1;
        end else if (ser_bit_valid) begin
            dist_reg <= dist_next;
        end
    end

    // ------------------------------------------------------------------
    // Elasticity buffer and output register source
    // ------------------------------------------------------------------
    logic [10:0] cur_word;
    logic [10:0] fill_word;
    logic [10:0] fifo_word;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_push;
    logic        fifo_pop;
    logic        del_comma;
    logic        overflow;
    logic        insert;
    logic        out_load;
    logic [10:0] out_word;

    assign cur_word  = make_word(sh_next, dec_en, native);
    assign fill_word = make_word(srcc_pkg::K28_5_RDN, dec_en, native);
    assign fifo_push = src_ref && char_end;
    // A full buffer sheds an arriving comma as a delete; losing data is flagged as overflow
    assign del_comma = fifo_push && !fifo_in_ready && is_k285;
    assign overflow  = fifo_push && !fifo_in_ready && !is_k285;
    assign fifo_pop  = src_ref && local_reference_clock;
    assign insert    = fifo_pop && !fifo_out_valid;
    assign out_load  = src_ref ? local_reference_clock : char_end;
    assign out_word  = !src_ref ? cur_word :
                       (fifo_out_valid ? fifo_word : fill_word);

    srcc_fifo #(
        .WIDTH (srcc_pkg::WORD_W),
        .DEPTH (srcc_pkg::FIFO_DEPTH)
    ) u_elastic (
        .sys_clk   (sys_clk),
        .rst       (rst || !src_ref),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (cur_word),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_word)
    );

    // Status: sticky events, write one to clear bits 4:1, framed cleared by a config write, a new event beats the clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stat_reg <= 5'h00;
        end else begin
            if (cfg_wr && stat_hit) begin
                stat_reg[4:1] <= stat_reg[4:1] & ~cfg_wdata[4:1];
            end
            if (cfg_wr && cfg_hit) begin
                stat_reg[srcc_pkg::ST_FRAMED] <= 1'b0;
            end
            if (realign) begin
                stat_reg[srcc_pkg::ST_FRAMED] <= 1'b1;
            end
            if (out_load && dec_en && out_word[8]) begin
                stat_reg[srcc_pkg::ST_CODE_ERR] <= 1'b1;
            end
            if (overflow) begin
                stat_reg[srcc_pkg::ST_OVERFLOW] <= 1'b1;
            end
            if (insert) begin
                stat_reg[srcc_pkg::ST_INSERT] <= 1'b1;
            end
            if (del_comma) begin
                stat_reg[srcc_pkg::ST_DELETE] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Output register and receive output clocks
    // ------------------------------------------------------------------
    logic [3:0] ph_reg;
    logic       clk_true_reg;
    logic       clk_true_next;
    logic       clk_comp_reg;

    assign rx_out_clk_true = clk_true_reg;
    assign rx_out_clk_comp = clk_comp_reg;

    // Output data register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_char_data    <= 10'h000;
            rx_char_special <= 1'b0;
        end else if (out_load) begin
            rx_char_data    <= out_word[9:0];
            rx_char_special <= out_word[10];
        end
    end

    // Full rate: high for half a character after each load; half rate: toggle per load
    always_comb begin
        clk_true_next = clk_true_reg;
        if (out_load) begin
            clk_true_next = half_rate ? !clk_true_reg : 1'b1;
        end else if (!half_rate && (ph_reg == 4'(srcc_pkg::CLK_HIGH_CYCLES - 1))) begin
            clk_true_next = 1'b0;
        end
    end

    // Both clock outputs come from flops; complement is built, not inverted, to avoid a glitch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clk_true_reg <= 1'b0;
            clk_comp_reg <= 1'b1;
            ph_reg       <= 4'hf;
        end else begin
            clk_true_reg <= clk_true_next;
            clk_comp_reg <= !clk_true_next;
            if (out_load) begin
                ph_reg <= 4'h0;
            end else if (ph_reg != 4'hf) begin
                ph_reg <= ph_reg + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_foreign_write: assert property (@(posedge sys_clk) disable iff (rst)
        (cfg_wr && !cfg_hit) |=> (cfg_reg == $past(cfg_reg)))
        else $error("Latch changed on a write to another address");

    a_k285_frame: assert property (@(posedge sys_clk) disable iff (rst)
        (fchar && fmode == srcc_pkg::FMODE_SINGLE && ser_bit_valid && is_k285) |-> char_end)
        else $error("K28.5 did not close a character");

    a_native_style: assert property (@(posedge sys_clk) disable iff (rst)
        (out_load && !src_ref && dec_en && !native) |=> !rx_char_special)
        else $error("Alternate style raised the native special flag");

    a_bypass_raw: assert property (@(posedge sys_clk) disable iff (rst)
        (out_load && !src_ref && !dec_en) |=> (rx_char_data == $past(sh_next)))
        else $error("Bypassed character not passed raw");

    a_recovered_load: assert property (@(posedge sys_clk) disable iff (rst)
        (!src_ref && char_end) |=> (ph_reg == 4'h0))
        else $error("Recovered character not loaded");

    a_insert_fill: assert property (@(posedge sys_clk) disable iff (rst)
        insert |=> ({rx_char_special, rx_char_data} == $past(fill_word)))
        else $error("Empty buffer did not present K28.5");

    a_half_toggle: assert property (@(posedge sys_clk) disable iff (rst)
        (out_load && half_rate) |=> (rx_out_clk_true != $past(rx_out_clk_true)) &&
                                    (rx_out_clk_comp == !rx_out_clk_true))
        else $error("Half-rate clocks did not toggle");

    a_full_high: assert property (@(posedge sys_clk) disable iff (rst)
        (out_load && !half_rate) ##1 (!out_load && !half_rate)[*5] |->
            rx_out_clk_true ##1 !rx_out_clk_true)
        else $error("Full-rate clock high phase wrong");

    a_multi_pair: assert property (@(posedge sys_clk) disable iff (rst)
        (fmode == srcc_pkg::FMODE_MULTI && realign) |->
            (seen_reg && (dist_next inside {6'h0a, 6'h14, 6'h1e, 6'h28})))
        else $error("Multi-byte framer realigned on a lone comma");

    c_multi_realign: cover property (@(posedge sys_clk) disable iff (rst)
        fmode == srcc_pkg::FMODE_MULTI && realign);
    c_insert: cover property (@(posedge sys_clk) disable iff (rst) insert);
    c_delete: cover property (@(posedge sys_clk) disable iff (rst) del_comma);
    c_half_load: cover property (@(posedge sys_clk) disable iff (rst) out_load && half_rate);
endmodule

// ===== testbench/srcc_upstream_model.sv
// Upstream link-layer model that latches characters off the output clocks
`timescale 1ns/1ps
module srcc_upstream_model (
    input  wire logic       rx_out_clk_true,
    input  wire logic       rx_out_clk_comp,
    input  wire logic       half_rate,
    input  wire logic [9:0] rx_char_data,
    output logic      [9:0] cap_data,
    output int              cap_count
);
    // ------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------
    initial cap_count = 0;
    // Data and clock change on one edge, so settle before latching
    always @(posedge rx_out_clk_true) begin
        #1 cap_data = rx_char_data;
        cap_count = cap_count + 1;
    end
    // Complement rising edge takes every other character in half rate
    always @(posedge rx_out_clk_comp) begin
        if (half_rate) begin
            #1 cap_data = rx_char_data;
            cap_count = cap_count + 1;
        end
    end
endmodule

// ===== testbench/srcc_rx_channel_tb_top.sv
// Self-checking bench for one receive channel
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
module srcc_rx_channel_tb_top;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic       sys_clk = 1'b0;
    logic       rst     = 1'b1;
    logic [3:0] cfg_addr = 4'h0;
    logic [7:0] cfg_wdata = 8'h00;
    logic       cfg_wr = 1'b0;
    logic       cfg_rd = 1'b0;
    logic [7:0] cfg_rdata;
    logic       ser_bit = 1'b0;
    logic       ser_bit_valid = 1'b0;
    logic       ref_pulse = 1'b0;
    logic       half_rate = 1'b0;
    logic [9:0] rx_char_data;
    logic [9:0] cap_data;
    logic       rx_char_special;
    logic       rx_out_clk_true;
    logic       rx_out_clk_comp;
    int         cap_count;
    int         num_errors = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    int         n;

    srcc_rx_channel srcc_rx_channel_i (.sys_clk(sys_clk), .rst(rst), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
        .ser_bit(ser_bit), .ser_bit_valid(ser_bit_valid), .local_reference_clock(ref_pulse),
        .rx_char_data(rx_char_data), .rx_char_special(rx_char_special),
        .rx_out_clk_true(rx_out_clk_true), .rx_out_clk_comp(rx_out_clk_comp));
    srcc_upstream_model srcc_upstream_model_i (.rx_out_clk_true(rx_out_clk_true),
        .rx_out_clk_comp(rx_out_clk_comp), .half_rate(half_rate),
        .rx_char_data(rx_char_data), .cap_data(cap_data), .cap_count(cap_count));

    // 20 MHz clock; the cycle ceiling cuts a hang short
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Bus and line tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_wr <= 1'b1;
        @(posedge sys_clk);
        cfg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        cfg_addr <= a;
        cfg_rd <= 1'b1;
        @(posedge sys_clk);
        cfg_rd <= 1'b0;
        #1 `CHK(cfg_rdata, exp)
    endtask
    // Ten bits, first-sent bit first; returns one cycle after the output register loads
    task automatic send(input logic [9:0] c);
        for (int i = 9; i >= 0; i--) begin
            @(posedge sys_clk);
            ser_bit <= c[i];
            ser_bit_valid <= 1'b1;
        end
        @(posedge sys_clk);
        ser_bit_valid <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    // Zero bits that push the stream off the character grid
    task automatic lead(input int nb);
        repeat (nb) begin
            @(posedge sys_clk);
            ser_bit <= 1'b0;
            ser_bit_valid <= 1'b1;
        end
        @(posedge sys_clk);
        ser_bit_valid <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd(4'h0, 8'h00);
        wr(4'h0, 8'hd6);
        wr(4'h1, 8'hff);
        rd(4'h0, 8'hd6);
        rd(4'h9, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_bypass();
        wr(4'h0, 8'h00);
        n = cap_count;
        send(10'h2a5);
        `CHK(rx_char_data, 10'h2a5)
        `CHK({rx_out_clk_true, rx_out_clk_comp}, 2'h2)
        repeat (5) @(posedge sys_clk);
        #1 `CHK({rx_out_clk_true, rx_out_clk_comp}, 2'h1)
        `CHK(cap_data, 10'h2a5)
        `CHK(cap_count, n + 1)
        $display("test bypass done");
    endtask
    task automatic t_decode();
        wr(4'h0, 8'h18);
        send(10'h0fa);
        `CHK({rx_char_special, rx_char_data}, 11'h4bc)
        wr(4'h0, 8'h10);
        send(10'h0fa);
        `CHK({rx_char_special, rx_char_data}, 11'h2bc)
        $display("test decode done");
    endtask
    task automatic t_half();
        logic t0;
        wr(4'h0, 8'h40);
        half_rate = 1'b1;
        send(10'h155);
        t0 = rx_out_clk_true;
        n = cap_count;
        send(10'h3c3);
        `CHK(rx_out_clk_true, !t0)
        `CHK(rx_out_clk_comp, t0)
        send(10'h0f0);
        `CHK(rx_out_clk_true, t0)
        `CHK(cap_data, 10'h0f0)
        `CHK(cap_count, n + 2)
        half_rate = 1'b0;
        $display("test half rate done");
    endtask
    // Empty buffer at a reference pulse must fill with a comma
    task automatic t_elastic();
        wr(4'h4, 8'h1e);
        wr(4'h0, 8'h38);
        @(posedge sys_clk);
        ref_pulse <= 1'b1;
        @(posedge sys_clk);
        ref_pulse <= 1'b0;
        for (int i = 0; i < 4 && rx_char_special !== 1'b1; i++) @(posedge sys_clk);
        #1 `CHK({rx_char_special, rx_char_data}, 11'h4bc)
        rd(4'h4, 8'h08);
        // Four words fill the buffer, so the trailing comma is shed
        repeat (4) send(10'h2a5);
        send(10'h0fa);
        rd(4'h4, 8'h18);
        @(posedge sys_clk);
        ref_pulse <= 1'b1;
        @(posedge sys_clk);
        ref_pulse <= 1'b0;
        @(posedge sys_clk);
        #1 `CHK({rx_char_special, rx_char_data}, 11'h055)
        $display("test elastic done");
    endtask
    // A lone comma off the grid must not move it; a second one ten bits on must
    task automatic t_frame();
        wr(4'h0, 8'h1e);
        wr(4'h4, 8'h1e);
        lead(3);
        send(10'h0fa);
        rd(4'h4, 8'h02);
        send(10'h0fa);
        `CHK({rx_char_special, rx_char_data}, 11'h4bc)
        rd(4'h4, 8'h03);
        $display("test framer done");
    endtask

    task automatic stop_test();
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_bypass();
        t_decode();
        t_half();
        t_elastic();
        t_frame();
        stop_test();
    end
endmodule
